// ---- hdl/fcc_defines.svh ----
`ifndef FCC_DEFINES_SVH
`define FCC_DEFINES_SVH

`define FCC_ADDR_W       24
`define FCC_DATA_W       16
`define FCC_ATTR_AW      14
`define FCC_PADDR_W      12
`define FCC_CNT_W        8

`define FCC_REG_CTRL     12'h000
`define FCC_REG_ADDR     12'h004
`define FCC_REG_WDATA    12'h008
`define FCC_REG_RDATA    12'h00c
`define FCC_REG_STATUS   12'h010

`define FCC_CTRL_OP_LSB    0
`define FCC_CTRL_LANE_LSB  4
`define FCC_CTRL_CECTL_BIT 8
`define FCC_CTRL_VPP_BIT   9
`define FCC_CTRL_GO_BIT    31
`define FCC_CTRL_RST       32'h0000_0030

`define FCC_ST_BUSY_BIT    0
`define FCC_ST_DONE_BIT    1
`define FCC_ST_REFUSED_BIT 2
`define FCC_ST_UNSAFE_BIT  3
`define FCC_ST_SUSP_BIT    4
`define FCC_ST_WP_BIT      5

`define FCC_CMD_SUSPEND  8'hb0
`define FCC_CMD_RESUME   8'hd0

`define FCC_CLK_NS       5
`define FCC_T_SETUP_NS   20
`define FCC_T_STROBE_NS  100
`define FCC_T_HOLD_NS    10
`define FCC_T_RECOV_NS   30
`define FCC_CYC(ns)      (((ns) + `FCC_CLK_NS - 1) / `FCC_CLK_NS)
`endif

// ---- hdl/fcc_pkg.sv ----
package fcc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD   = 3'b011,
        ST_RECOV  = 3'b100
    } fcc_state_e;

    typedef enum logic [1:0] {
        OP_CMN_RD = 2'b00,
        OP_CMN_WR = 2'b01,
        OP_ATT_RD = 2'b10,
        OP_ATT_WR = 2'b11
    } fcc_op_e;
endpackage

// ---- hdl/fcc_ctl_if.sv ----
`timescale 1ns/1ps
`include "fcc_defines.svh"
interface fcc_ctl_if #(parameter int AW = `FCC_ADDR_W);
    logic                   start;
    fcc_pkg::fcc_op_e       op;
    logic [1:0]             lanes;
    logic                   cectl;
    logic                   vpp_req;
    logic [AW-1:0]          addr;
    logic [`FCC_DATA_W-1:0] wdata;
    logic [`FCC_DATA_W-1:0] rdata;
    logic                   busy;
    logic                   done;
    logic                   refused;
    logic                   unsafe;
    logic                   susp;
    logic                   wp;

    modport regs (
        output start, op, lanes, cectl, vpp_req, addr, wdata,
        input  rdata, busy, done, refused, unsafe, susp, wp
    );
    modport seq (
        input  start, op, lanes, cectl, vpp_req, addr, wdata,
        output rdata, busy, done, refused, unsafe, susp, wp
    );
endinterface

// ---- hdl/fcc_cnt.sv ----
`timescale 1ns/1ps
module fcc_cnt #(
    parameter int W = 8
) (
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] val_i,
    output logic              zero_o
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= val_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign zero_o = (cnt_q == '0);
endmodule

// ---- hdl/fcc_regs.sv ----
`timescale 1ns/1ps
`include "fcc_defines.svh"
module fcc_regs (
    input  wire logic                    core_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [`FCC_PADDR_W-1:0] paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    fcc_ctl_if.regs                      ctl
);
    logic [31:0] ctrl_q;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] prdata_q;
    logic        done_q;
    logic        refused_q;
    logic        unsafe_q;
    logic        mapped;
    logic        acc_wr;
    logic [31:0] status;
    logic [31:0] rd_mux;

    // -------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------
    assign mapped = (paddr_i == `FCC_REG_CTRL) || (paddr_i == `FCC_REG_ADDR) ||
                    (paddr_i == `FCC_REG_WDATA) || (paddr_i == `FCC_REG_RDATA) ||
                    (paddr_i == `FCC_REG_STATUS);
    assign acc_wr    = psel_i && penable_i && pwrite_i && mapped;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;

    // The op, lane and CE-control fields come straight from the write so that a start uses the value written with it.
    assign ctl.start   = acc_wr && (paddr_i == `FCC_REG_CTRL) && pwdata_i[`FCC_CTRL_GO_BIT];
    assign ctl.op      = fcc_pkg::fcc_op_e'(pwdata_i[`FCC_CTRL_OP_LSB +: 2]);
    assign ctl.lanes   = pwdata_i[`FCC_CTRL_LANE_LSB +: 2];
    assign ctl.cectl   = pwdata_i[`FCC_CTRL_CECTL_BIT];
    assign ctl.vpp_req = ctrl_q[`FCC_CTRL_VPP_BIT];
    assign ctl.addr    = addr_q[$bits(ctl.addr)-1:0];
    assign ctl.wdata   = wdata_q[`FCC_DATA_W-1:0];

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q  <= `FCC_CTRL_RST;
            addr_q  <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
        end else if (acc_wr) begin
            if (paddr_i == `FCC_REG_CTRL) begin
                ctrl_q <= pwdata_i & ~(32'h0000_0001 << `FCC_CTRL_GO_BIT);
            end
            if (paddr_i == `FCC_REG_ADDR) begin
                addr_q <= pwdata_i & ((32'h0000_0001 << `FCC_ADDR_W) - 32'h0000_0001);
            end
            if (paddr_i == `FCC_REG_WDATA) begin
                wdata_q <= {16'h0000, pwdata_i[`FCC_DATA_W-1:0]};
            end
        end
    end

    // Sticky flags: a new event in the clearing cycle wins over the clear.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_q    <= 1'b0;
            refused_q <= 1'b0;
            unsafe_q  <= 1'b0;
        end else begin
            if (acc_wr && (paddr_i == `FCC_REG_STATUS)) begin
                done_q    <= ctl.done || (done_q && !pwdata_i[`FCC_ST_DONE_BIT]);
                refused_q <= ctl.refused || (refused_q && !pwdata_i[`FCC_ST_REFUSED_BIT]);
                unsafe_q  <= ctl.unsafe || (unsafe_q && !pwdata_i[`FCC_ST_UNSAFE_BIT]);
            end else begin
                done_q    <= done_q || ctl.done;
                refused_q <= refused_q || ctl.refused;
                unsafe_q  <= unsafe_q || ctl.unsafe;
            end
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[`FCC_ST_BUSY_BIT]    = ctl.busy;
        status[`FCC_ST_DONE_BIT]    = done_q;
        status[`FCC_ST_REFUSED_BIT] = refused_q;
        status[`FCC_ST_UNSAFE_BIT]  = unsafe_q;
        status[`FCC_ST_SUSP_BIT]    = ctl.susp;
        status[`FCC_ST_WP_BIT]      = ctl.wp;
        unique case (paddr_i)
            `FCC_REG_CTRL:   rd_mux = ctrl_q;
            `FCC_REG_ADDR:   rd_mux = addr_q;
            `FCC_REG_WDATA:  rd_mux = wdata_q;
            `FCC_REG_RDATA:  rd_mux = {16'h0000, ctl.rdata};
            `FCC_REG_STATUS: rd_mux = status;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is sampled in the setup cycle and presented in the access cycle.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel_i && !penable_i) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata_o = prdata_q;

    chk_unmapped_err: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (psel_i && penable_i && !mapped) |->
        pslverr_o && (pwrite_i || (prdata_o == 32'h0000_0000)))
        else $error("Unmapped access without error answer.");
endmodule

// ---- hdl/fcc_host.sv ----
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "fcc_defines.svh"
module fcc_host #(
    parameter int AW         = `FCC_ADDR_W,
    parameter int SETUP_CYC  = `FCC_CYC(`FCC_T_SETUP_NS),
    parameter int STROBE_CYC = `FCC_CYC(`FCC_T_STROBE_NS),
    parameter int HOLD_CYC   = `FCC_CYC(`FCC_T_HOLD_NS),
    parameter int RECOV_CYC  = `FCC_CYC(`FCC_T_RECOV_NS)
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [`FCC_PADDR_W-1:0] paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    output logic      [AW-1:0]           card_addr_o,
    output logic      [`FCC_DATA_W-1:0]  card_data_o,
    input  wire logic [`FCC_DATA_W-1:0]  card_data_i,
    output logic                         card_data_oe_n_o,
    output logic                         card_ce1_n_o,
    output logic                         card_ce2_n_o,
    output logic                         card_oe_n_o,
    output logic                         card_we_n_o,
    output logic                         card_reg_n_o,
    output logic                         prog_voltage_high_o,
    input  wire logic                    protect_i
);
    localparam int CW = `FCC_CNT_W;

    fcc_ctl_if #(.AW(AW)) ctl ();

    fcc_regs u_regs (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .psel_i     (psel_i),
        .penable_i  (penable_i),
        .pwrite_i   (pwrite_i),
        .paddr_i    (paddr_i),
        .pwdata_i   (pwdata_i),
        .prdata_o   (prdata_o),
        .pready_o   (pready_o),
        .pslverr_o  (pslverr_o),
        .ctl        (ctl)
    );

    fcc_pkg::fcc_state_e state_q;
    fcc_pkg::fcc_state_e state_d;
    logic                wr_q;
    logic                attr_q;
    logic                cectl_q;
    logic [1:0]          lanes_q;
    logic [`FCC_DATA_W-1:0] wdata_q;
    logic [`FCC_DATA_W-1:0] rdata_q;
    logic                start_wr;
    logic                start_ok;
    logic                wr_n;
    logic                attr_n;
    logic                cectl_n;
    logic [1:0]          lanes_n;
    logic                cnt_load;
    logic [CW-1:0]       cnt_val;
    logic                cnt_zero;
    logic                ce_act;
    logic                we_act;
    logic                oe_act;
    logic                drv;
    logic                xfer_end;
    logic                susp_q;
    logic                pend_q;
    logic                vreq_q;
    logic                vpp_q;

    // -------------------------------------------------------------
    // Request acceptance
    // -------------------------------------------------------------
    assign start_wr = (ctl.op == fcc_pkg::OP_CMN_WR) || (ctl.op == fcc_pkg::OP_ATT_WR);
    // A write while the protect pin is high would be dropped by the card, so refuse it.
    assign start_ok = ctl.start && (state_q == fcc_pkg::ST_IDLE) && (ctl.lanes != 2'b00) &&
                      !(start_wr && protect_i);
    assign ctl.refused = ctl.start && !start_ok;
    assign ctl.busy    = (state_q != fcc_pkg::ST_IDLE);
    assign ctl.wp      = protect_i;

    assign wr_n    = start_ok ? start_wr : wr_q;
    assign attr_n  = start_ok ? ctl.op[1] : attr_q;
    assign cectl_n = start_ok ? ctl.cectl : cectl_q;
    assign lanes_n = start_ok ? ctl.lanes : lanes_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q        <= 1'b0;
            attr_q      <= 1'b0;
            cectl_q     <= 1'b0;
            lanes_q     <= 2'b00;
            wdata_q     <= 16'h0000;
            card_addr_o <= '0;
        end else if (start_ok) begin
            wr_q    <= start_wr;
            attr_q  <= ctl.op[1];
            cectl_q <= ctl.cectl;
            lanes_q <= ctl.lanes;
            // An upper-only byte travels on the high lanes.
            wdata_q <= (ctl.lanes == 2'b10) ? {ctl.wdata[7:0], 8'h00} : ctl.wdata;
            // Attribute space decodes only the low address lines.
            card_addr_o <= ctl.op[1] ?
                (ctl.addr & AW'((1 << `FCC_ATTR_AW) - 1)) : ctl.addr;
        end
    end

    // -------------------------------------------------------------
    // Cycle sequencer
    // -------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fcc_pkg::ST_IDLE:   if (start_ok) state_d = fcc_pkg::ST_SETUP;
            fcc_pkg::ST_SETUP:  if (cnt_zero) state_d = fcc_pkg::ST_STROBE;
            fcc_pkg::ST_STROBE: if (cnt_zero) state_d = fcc_pkg::ST_HOLD;
            fcc_pkg::ST_HOLD:   if (cnt_zero) state_d = fcc_pkg::ST_RECOV;
            fcc_pkg::ST_RECOV:  if (cnt_zero) state_d = fcc_pkg::ST_IDLE;
            default:            state_d = fcc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= fcc_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign cnt_load = (state_d != state_q);
    always_comb begin
        unique case (state_d)
            fcc_pkg::ST_SETUP:  cnt_val = CW'(SETUP_CYC - 1);
            fcc_pkg::ST_STROBE: cnt_val = CW'(STROBE_CYC - 1);
            fcc_pkg::ST_HOLD:   cnt_val = CW'(HOLD_CYC - 1);
            fcc_pkg::ST_RECOV:  cnt_val = CW'(RECOV_CYC - 1);
            default:            cnt_val = '0;
        endcase
    end

    fcc_cnt #(.W(CW)) u_cnt (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .load_i     (cnt_load),
        .val_i      (cnt_val),
        .zero_o     (cnt_zero)
    );

    // -------------------------------------------------------------
    // Card pins
    // -------------------------------------------------------------
    // Pins are decoded from the next state and registered, so strobes never glitch.
    // In a CE-controlled write WE leads and trails, so CE's rising edge ends the cycle.
    always_comb begin
        ce_act = ((state_d == fcc_pkg::ST_SETUP) && !(wr_n && cectl_n)) ||
                 (state_d == fcc_pkg::ST_STROBE) ||
                 ((state_d == fcc_pkg::ST_HOLD) && wr_n && !cectl_n);
        we_act = wr_n && ((state_d == fcc_pkg::ST_STROBE) ||
                 (cectl_n && ((state_d == fcc_pkg::ST_SETUP) ||
                              (state_d == fcc_pkg::ST_HOLD))));
        oe_act = !wr_n && (state_d == fcc_pkg::ST_STROBE);
        // Data stays driven past the ending rising edge for the card to latch it.
        drv    = wr_n && (state_d != fcc_pkg::ST_IDLE) &&
                 (state_d != fcc_pkg::ST_RECOV);
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            card_ce1_n_o     <= 1'b1;
            card_ce2_n_o     <= 1'b1;
            card_oe_n_o      <= 1'b1;
            card_we_n_o      <= 1'b1;
            card_reg_n_o     <= 1'b1;
            card_data_oe_n_o <= 1'b1;
        end else begin
            card_ce1_n_o     <= !(ce_act && lanes_n[0]);
            card_ce2_n_o     <= !(ce_act && lanes_n[1]);
            card_oe_n_o      <= !oe_act;
            card_we_n_o      <= !we_act;
            card_reg_n_o     <= !(attr_n && (state_d != fcc_pkg::ST_IDLE));
            card_data_oe_n_o <= !drv;
        end
    end
    assign card_data_o = wdata_q;

    // Read data is taken in the last cycle of OE low; OE and CE then rise before any
    // further read, which is what refreshes the card's status latch.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 16'h0000;
        end else if ((state_q == fcc_pkg::ST_STROBE) && cnt_zero && !wr_q) begin
            unique case (lanes_q)
                2'b01:   rdata_q <= {8'h00, card_data_i[7:0]};
                2'b10:   rdata_q <= {8'h00, card_data_i[15:8]};
                default: rdata_q <= card_data_i;
            endcase
        end
    end
    assign ctl.rdata = rdata_q;

    assign xfer_end = (state_q == fcc_pkg::ST_RECOV) && cnt_zero;
    assign ctl.done = xfer_end;

    // -------------------------------------------------------------
    // Programming voltage
    // -------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            susp_q <= 1'b0;
        end else if (xfer_end && wr_q && !attr_q) begin
            if (wdata_q[7:0] == `FCC_CMD_SUSPEND) begin
                susp_q <= 1'b1;
            end else if (wdata_q[7:0] == `FCC_CMD_RESUME) begin
                susp_q <= 1'b0;
            end
        end
    end
    assign ctl.susp = susp_q;

    // A common write made at high voltage may be a program or erase still running.
    // Clearing the VPP request bit before a later common read flags the result as unreliable, even while a suspend holds the voltage high.
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_q <= 1'b0;
            vreq_q <= 1'b0;
            vpp_q  <= 1'b0;
        end else begin
            vreq_q <= ctl.vpp_req;
            vpp_q  <= ctl.vpp_req || susp_q;
            if (xfer_end && !attr_q) begin
                pend_q <= wr_q && vpp_q;
            end
        end
    end
    assign ctl.unsafe          = pend_q && vreq_q && !ctl.vpp_req;
    assign prog_voltage_high_o = vpp_q;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_write_oe_high: assert property (!card_we_n_o |-> card_oe_n_o)
        else $error("WE low while OE low.");
    chk_data_hold: assert property ((state_q == fcc_pkg::ST_HOLD) && wr_q |->
        !card_data_oe_n_o && $stable(card_data_o))
        else $error("Write data not held past ending edge.");
    chk_read_release: assert property ((state_q == fcc_pkg::ST_STROBE) && cnt_zero &&
        !wr_q |=> card_oe_n_o && card_ce1_n_o && card_ce2_n_o)
        else $error("OE and CE not raised after a read.");
    chk_protect_refuse: assert property (ctl.start && start_wr && protect_i |=>
        card_we_n_o && !$rose(ctl.busy))
        else $error("Write started while protected.");
    chk_susp_vpp: assert property (susp_q |=> prog_voltage_high_o)
        else $error("Voltage low during suspend.");
    chk_suspend_set: assert property (xfer_end && wr_q && !attr_q &&
        (wdata_q[7:0] == `FCC_CMD_SUSPEND) |=> susp_q ##1 prog_voltage_high_o)
        else $error("Suspend not tracked.");
    chk_attr_addr: assert property (!card_reg_n_o |->
        (card_addr_o >> `FCC_ATTR_AW) == '0)
        else $error("Attribute address above line 13.");
    chk_lane_width: assert property ((state_q == fcc_pkg::ST_STROBE) |->
        (card_ce1_n_o == !lanes_q[0]) && (card_ce2_n_o == !lanes_q[1]))
        else $error("Card enables do not match lanes.");
    chk_idle_pins: assert property ((state_q == fcc_pkg::ST_IDLE) |->
        card_ce1_n_o && card_ce2_n_o && card_we_n_o && card_data_oe_n_o)
        else $error("Card strobes active while idle.");

    cov_we_write: cover property (start_ok && start_wr && !ctl.cectl);
    cov_ce_write: cover property (start_ok && start_wr && ctl.cectl);
    cov_attr_read: cover property (start_ok && (ctl.op == fcc_pkg::OP_ATT_RD));
    cov_suspend: cover property ($rose(susp_q));
endmodule

// ---- tb/fcc_card_model.sv ----
`timescale 1ns/1ps
module fcc_card_model #(
    parameter logic [7:0] MAKER  = 8'h5a,
    parameter logic [7:0] DEVICE = 8'h3c
) (
    input  wire logic        ce1_n_i,
    input  wire logic        ce2_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        reg_n_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [15:0] data_i,
    input  wire logic        dio_n_i,
    output logic      [15:0] data_o
);
    // Maker and device codes above are arbitrary values.
    logic [1:0]  src_q = 2'd0;
    logic        susp_q = 1'b0;
    logic [15:0] val;
    logic [15:0] hold_q = 16'h0000;
    logic [7:0]  attr_q [0:15];
    wire sel = !(ce1_n_i & ce2_n_i);
    wire wr  = sel & oe_n_i & !we_n_i;
    wire drv = sel & !oe_n_i & we_n_i;
    // Undriven host data reads inverted, so a late or early release corrupts the command.
    wire [15:0] din = dio_n_i ? ~data_i : data_i;
    always @(negedge wr) begin
        if (!reg_n_i) attr_q[addr_i[3:0]] <= din[7:0];
        else case (din[7:0])
            8'hff: src_q <= 2'd0;
            8'h90: src_q <= 2'd1;
            8'h70, 8'h40, 8'h20: src_q <= 2'd2;
            8'hb0: begin susp_q <= 1'b1; src_q <= 2'd2; end
            8'hd0: begin susp_q <= 1'b0; src_q <= 2'd2; end
            default: ;
        endcase
    end
    always_comb begin
        if (!reg_n_i) val = {8'hff, attr_q[addr_i[3:0]]};
        else if (src_q == 2'd1) val = {8'h00, addr_i[0] ? DEVICE : MAKER};
        else if (src_q == 2'd2) val = {8'h00, 1'b1, susp_q, 6'h00};
        else val = addr_i[15:0] ^ 16'h1234;
    end
    // Released lines show the inverse of the last value, never a stale copy.
    always @(negedge drv) hold_q <= ~val;
    assign data_o = drv ? val : hold_q;
endmodule

// ---- tb/flash_card_command_modes_bench.sv ----
`timescale 1ns/1ps
`include "fcc_defines.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module flash_card_command_modes_bench;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, prot = 0, rdy, slverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [23:0] caddr;
    logic [15:0] cdo, cdi;
    logic ce1, ce2, oe, we, regn, dion, vpp;
    logic [1:0] ln = 2'b11;
    int err_total = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    fcc_host u_fcc_host (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(rdy), .pslverr_o(slverr), .card_addr_o(caddr), .card_data_o(cdo),
        .card_data_i(cdi), .card_data_oe_n_o(dion), .card_ce1_n_o(ce1), .card_ce2_n_o(ce2),
        .card_oe_n_o(oe), .card_we_n_o(we), .card_reg_n_o(regn),
        .prog_voltage_high_o(vpp), .protect_i(prot));
    fcc_card_model u_fcc_card_model (.ce1_n_i(ce1), .ce2_n_i(ce2), .oe_n_i(oe), .we_n_i(we),
        .reg_n_i(regn), .addr_i(caddr), .data_i(cdo), .dio_n_i(dion), .data_o(cdi));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        r = prdata;
        psel <= 0; penable <= 0;
    endtask
    task automatic card(input logic [1:0] op, input logic ce, input logic [23:0] a,
                        input logic [15:0] d);
        apb(1, `FCC_REG_ADDR, {8'h00, a});
        apb(1, `FCC_REG_WDATA, {16'h0000, d});
        apb(1, `FCC_REG_CTRL, {1'b1, 21'd0, 1'b1, ce, 2'b00, ln, 2'b00, op});
        r = 0;
        for (int n = 0; n < 100 && r[1] !== 1'b1; n++) apb(0, `FCC_REG_STATUS, 0);
        if (r[1] !== 1'b1) err_total++;
        apb(1, `FCC_REG_STATUS, 32'h0000_0002);
        apb(0, `FCC_REG_RDATA, 0);
    endtask
    task automatic test_done;
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1;
        apb(0, `FCC_REG_CTRL, 0); `CHK(r, 32'h0000_0030)
        apb(0, `FCC_REG_STATUS, 0); `CHK(r[5:0], 6'h00)
        apb(0, 12'h020, 0); `CHK(slverr, 1'b1)
        card(2'd0, 0, 24'h000010, 0); `CHK(r[15:0], 16'h1224)
        card(2'd1, 0, 0, 16'h0090); card(2'd0, 0, 0, 0); `CHK(r[15:0], 16'h005a)
        card(2'd0, 0, 1, 0); `CHK(r[15:0], 16'h003c)
        card(2'd1, 1, 0, 16'h00b0); apb(0, `FCC_REG_STATUS, 0); `CHK(r[4], 1'b1)
        apb(1, `FCC_REG_CTRL, 32'h0000_0030);
        apb(0, `FCC_REG_STATUS, 0); `CHK(r[3], 1'b1)
        `CHK(vpp, 1'b1)
        apb(1, `FCC_REG_STATUS, 32'h0000_0008);
        card(2'd0, 0, 0, 0); `CHK(r[15:0], 16'h00c0)
        card(2'd1, 0, 0, 16'h00d0); apb(0, `FCC_REG_STATUS, 0); `CHK(r[4], 1'b0)
        card(2'd0, 0, 0, 0); `CHK(r[15:0], 16'h0080)
        card(2'd1, 0, 0, 16'h00ff); card(2'd0, 0, 24'h5, 0); `CHK(r[15:0], 16'h1231)
        ln = 2'b01; card(2'd0, 0, 24'h5, 0); `CHK(r[15:0], 16'h0031)
        ln = 2'b10; card(2'd0, 0, 24'h5, 0); `CHK(r[15:0], 16'h0012)
        ln = 2'b11;
        card(2'd3, 1, 24'h3, 16'h00a5); card(2'd2, 0, 24'h3, 0); `CHK(r[15:0], 16'hffa5)
        prot <= 1;
        apb(1, `FCC_REG_CTRL, 32'h8000_0031);
        apb(0, `FCC_REG_STATUS, 0); `CHK(r[5:0], 6'h24)
        `CHK(vpp, 1'b0)
        test_done;
    end
endmodule
